// ---- logic/rhms_pkg.sv ----
// rhms_pkg: constants, mode codes, carriers and states of the
// reset halt and mode select block.
// assumes a single 125 MHz system clock shared by every user.
`default_nettype none
package rhms_pkg;

    localparam int RHMS_MODE_W = 4;
    localparam int RHMS_PORT_W = 4;

    typedef logic [RHMS_MODE_W-1:0] rhms_mode_t;
    typedef logic [RHMS_PORT_W-1:0] rhms_port_t;

    // operating mode strap codes
    localparam rhms_mode_t RHMS_MODE_NORMAL = 4'h0;
    localparam rhms_mode_t RHMS_MODE_EEPROM = 4'h1;
    localparam rhms_mode_t RHMS_MODE_RSV_LO = 4'h2;
    localparam rhms_mode_t RHMS_MODE_RSV_HI = 4'h7;
    localparam rhms_mode_t RHMS_MODE_FAILOVER = 4'h8;
    localparam rhms_mode_t RHMS_MODE_EE_FO = 4'h9;
    localparam rhms_mode_t RHMS_MODE_EE_FO_ALT = 4'hA;

    localparam rhms_port_t RHMS_UPSTREAM_PORT0 = 4'h0;
    localparam rhms_port_t RHMS_ALT_PORT_DEF = 4'h2;

    // length of the internal reset procedure
    localparam int RHMS_CLK_PERIOD_NS = 8;
    localparam int RHMS_RESET_PROC_NS = 1000;
    localparam int RHMS_RESET_PROC_CYC =
        (RHMS_RESET_PROC_NS + RHMS_CLK_PERIOD_NS - 1) / RHMS_CLK_PERIOD_NS;

    // strap reset values of the synchronisers
    localparam logic RHMS_FUND_RST_N_RST = 1'b0;
    localparam logic RHMS_HOLD_REQ_RST = 1'b0;
    localparam rhms_mode_t RHMS_MODE_RST = 4'h0;

    typedef struct packed {
        logic eeprom_init;
        logic failover;
        rhms_port_t upstream_port;
        logic reserved;
    } rhms_cfg_t;

    typedef struct packed {
        logic core_reset_n;
        logic link_fund_reset;
        logic smbus_enable;
        logic switch_enable;
        logic halted;
    } rhms_ctl_t;

    typedef enum logic [2:0] {
        RHMS_ST_FUND,
        RHMS_ST_INIT,
        RHMS_ST_HALT,
        RHMS_ST_EEPROM,
        RHMS_ST_RUN
    } rhms_state_t;

endpackage : rhms_pkg
`default_nettype wire

// ---- logic/rhms_sync.sv ----
// rhms_sync: three flip-flop input synchroniser for board pins.
// assumes the pin is asynchronous to clk; output moves only once
// the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module rhms_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,               // system clock
    input wire logic rstn,              // synchronous reset, active low
    input wire logic [WIDTH-1:0] pin,   // asynchronous pin level
    output logic [WIDTH-1:0] level      // filtered synchronous level
);
    logic [WIDTH-1:0] ff1_reg;
    logic [WIDTH-1:0] ff2_reg;
    logic [WIDTH-1:0] ff3_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ff1_reg <= RST_VAL;
            ff2_reg <= RST_VAL;
            ff3_reg <= RST_VAL;
        end else begin
            ff1_reg <= pin;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
        end
    end

    // a one-cycle disagreement is a glitch still settling, not a change
    always_ff @(posedge clk) begin
        if (!rstn) begin
            level <= RST_VAL;
        end else if (ff2_reg == ff3_reg) begin
            level <= ff3_reg;
        end
    end
endmodule : rhms_sync
`default_nettype wire

// ---- logic/rhms_top.sv ----
// rhms_top: reset halt and operating mode select for the switch core.
// assumes the smbus slave logic pulses halt_bit_clear when a master
// clears the halt bit, and the eeprom loader pulses eeprom_init_done.
//
// Overview of operation
// - halt request in reset: finish reset procedure, then hold with smbus on.
// - leave the halted state only when an smbus master clears the halt bit or a fundamental reset arrives.
// - code 0x0 normal operation; 0x1 normal after serial eeprom load.
// - code 0x8 normal with upstream failover, port 0 upstream.
// - code 0x9 eeprom load plus upstream failover, port 0 upstream.
// - code 0xA eeprom load plus failover, upstream port set by parameter.
// - fundamental reset holds the core in reset, clears the halt bit and resets the serial links.
`timescale 1ns/1ps
`default_nettype none
module rhms_top
    import rhms_pkg::*;
#(
    parameter int RESET_PROC_CYCLES = RHMS_RESET_PROC_CYC,
    parameter rhms_pkg::rhms_port_t ALT_UPSTREAM_PORT =
        rhms_pkg::RHMS_ALT_PORT_DEF
) (
    input wire logic clk,                          // system clock
    input wire logic rstn,                         // sync reset, active low
    input wire logic fundamental_reset_n,          // reset pin, active low
    input wire logic reset_hold_request,           // halt strap pin
    input wire rhms_pkg::rhms_mode_t operating_mode_strap, // mode straps
    input wire logic halt_bit_clear,               // smbus clears halt bit
    input wire logic eeprom_init_done,             // eeprom load finished
    output rhms_pkg::rhms_ctl_t ctl,               // core and link controls
    output rhms_pkg::rhms_cfg_t cfg,               // decoded mode
    output rhms_pkg::rhms_mode_t mode_latched,     // sampled strap value
    output logic halt_bit,                         // halt bit readback
    output logic eeprom_init_start                 // one-cycle load request
);
    import rhms_pkg::*;

    localparam int CNT_W = $clog2(RESET_PROC_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST =
        CNT_W'(RESET_PROC_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    function automatic rhms_cfg_t decode_mode(input rhms_mode_t m);
        rhms_cfg_t c;
        c = '0;
        c.upstream_port = RHMS_UPSTREAM_PORT0;
        case (m)
            RHMS_MODE_NORMAL: begin
            end
            RHMS_MODE_EEPROM: begin
                c.eeprom_init = 1'b1;
            end
            RHMS_MODE_FAILOVER: begin
                c.failover = 1'b1;
            end
            RHMS_MODE_EE_FO: begin
                c.eeprom_init = 1'b1;
                c.failover = 1'b1;
            end
            RHMS_MODE_EE_FO_ALT: begin
                c.eeprom_init = 1'b1;
                c.failover = 1'b1;
                c.upstream_port = ALT_UPSTREAM_PORT;
            end
            default: begin
                // undefined codes run as plain normal mode, flagged
                c.reserved = 1'b1;
            end
        endcase
        return c;
    endfunction : decode_mode

    function automatic rhms_ctl_t ctl_of(input rhms_state_t s);
        rhms_ctl_t k;
        k = '0;
        case (s)
            RHMS_ST_FUND: begin
                k.link_fund_reset = 1'b1;
            end
            RHMS_ST_INIT: begin
            end
            RHMS_ST_HALT: begin
                k.smbus_enable = 1'b1;
                k.halted = 1'b1;
            end
            RHMS_ST_EEPROM: begin
                k.core_reset_n = 1'b1;
                k.smbus_enable = 1'b1;
            end
            RHMS_ST_RUN: begin
                k.core_reset_n = 1'b1;
                k.smbus_enable = 1'b1;
                k.switch_enable = 1'b1;
            end
            default: begin
                k.link_fund_reset = 1'b1;
            end
        endcase
        return k;
    endfunction : ctl_of

    logic fund_ok;
    logic hold_req_s;
    rhms_mode_t strap_s;
    rhms_state_t state_reg;
    rhms_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic sample;
    logic proc_done;

    rhms_sync #(.WIDTH(1), .RST_VAL(RHMS_FUND_RST_N_RST)) u_sync_fund (
        .clk(clk),
        .rstn(rstn),
        .pin(fundamental_reset_n),
        .level(fund_ok)
    );

    rhms_sync #(.WIDTH(1), .RST_VAL(RHMS_HOLD_REQ_RST)) u_sync_hold (
        .clk(clk),
        .rstn(rstn),
        .pin(reset_hold_request),
        .level(hold_req_s)
    );

    rhms_sync #(.WIDTH(RHMS_MODE_W), .RST_VAL(RHMS_MODE_RST)) u_sync_mode (
        .clk(clk),
        .rstn(rstn),
        .pin(operating_mode_strap),
        .level(strap_s)
    );

    assign sample = (state_reg == RHMS_ST_FUND) && fund_ok;
    assign proc_done = (state_reg == RHMS_ST_INIT) && (cnt_reg == CNT_LAST);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RHMS_ST_FUND: begin
                if (fund_ok) begin
                    state_next = RHMS_ST_INIT;
                end
            end
            RHMS_ST_INIT: begin
                if (proc_done) begin
                    if (halt_bit) begin
                        state_next = RHMS_ST_HALT;
                    end else if (cfg.eeprom_init) begin
                        state_next = RHMS_ST_EEPROM;
                    end else begin
                        state_next = RHMS_ST_RUN;
                    end
                end
            end
            RHMS_ST_HALT: begin
                if (!halt_bit) begin
                    if (cfg.eeprom_init) begin
                        state_next = RHMS_ST_EEPROM;
                    end else begin
                        state_next = RHMS_ST_RUN;
                    end
                end
            end
            RHMS_ST_EEPROM: begin
                if (eeprom_init_done) begin
                    state_next = RHMS_ST_RUN;
                end
            end
            RHMS_ST_RUN: begin
            end
            default: begin
                state_next = RHMS_ST_FUND;
            end
        endcase
        if (!fund_ok) begin
            state_next = RHMS_ST_FUND;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= RHMS_ST_FUND;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || state_reg != RHMS_ST_INIT) begin
            cnt_reg <= CNT_ZERO;
        end else if (!proc_done) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // outputs follow state_next so they line up with state_reg
    // registered controls for every state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctl <= ctl_of(RHMS_ST_FUND);
        end else begin
            ctl <= ctl_of(state_next);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mode_latched <= RHMS_MODE_RST;
            cfg <= decode_mode(RHMS_MODE_RST);
        end else if (sample) begin
            mode_latched <= strap_s;
            cfg <= decode_mode(strap_s);
        end
    end

    // halt bit: loaded at release, cleared afterwards over smbus or by fundamental reset;
    // a clear in the sampling cycle loses to the load
    always_ff @(posedge clk) begin
        if (!rstn) begin
            halt_bit <= 1'b0;
        end else if (sample) begin
            halt_bit <= hold_req_s;
        end else if (state_reg == RHMS_ST_FUND || !fund_ok) begin
            halt_bit <= 1'b0;
        end else if (halt_bit_clear) begin
            halt_bit <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            eeprom_init_start <= 1'b0;
        end else begin
            eeprom_init_start <= (state_next == RHMS_ST_EEPROM) &&
                                 (state_reg != RHMS_ST_EEPROM);
        end
    end

    halt_entry_a: assert property (@(posedge clk) disable iff (!rstn)
        proc_done && halt_bit && fund_ok |=> ctl.halted && ctl.smbus_enable)
        else $error("halt not entered after reset procedure");
    halt_procdur_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(ctl.halted) |-> $past(state_reg, 1) == RHMS_ST_INIT
            && $past(cnt_reg, 1) == CNT_LAST)
        else $error("halt entered before reset procedure done");
    halt_stay_a: assert property (@(posedge clk) disable iff (!rstn)
        state_reg == RHMS_ST_HALT && halt_bit && fund_ok |=>
            state_reg == RHMS_ST_HALT)
        else $error("halt left while halt bit still set");
    halt_exit_a: assert property (@(posedge clk) disable iff (!rstn)
        state_reg == RHMS_ST_HALT && halt_bit_clear && fund_ok |=>
            ##1 !ctl.halted && ctl.core_reset_n)
        else $error("halt not left after halt bit clear");
    mode_base_a: assert property (@(posedge clk) disable iff (!rstn)
        state_reg == RHMS_ST_INIT && mode_latched == RHMS_MODE_NORMAL |->
            !cfg.eeprom_init && !cfg.failover && !cfg.reserved)
        else $error("mode 0 decoded wrongly");
    mode_ee_a: assert property (@(posedge clk) disable iff (!rstn)
        eeprom_init_start |-> cfg.eeprom_init && mode_latched[0] !=
            mode_latched[1] && !cfg.reserved)
        else $error("eeprom load started in a mode without it");
    mode_fo_a: assert property (@(posedge clk) disable iff (!rstn)
        state_reg != RHMS_ST_FUND && mode_latched == RHMS_MODE_FAILOVER |->
            cfg.failover && !cfg.eeprom_init &&
            cfg.upstream_port == RHMS_UPSTREAM_PORT0)
        else $error("mode 8 decoded wrongly");
    mode_eefo_a: assert property (@(posedge clk) disable iff (!rstn)
        state_reg != RHMS_ST_FUND && mode_latched == RHMS_MODE_EE_FO |->
            cfg.failover && cfg.eeprom_init &&
            cfg.upstream_port == RHMS_UPSTREAM_PORT0)
        else $error("mode 9 decoded wrongly");
    mode_alt_a: assert property (@(posedge clk) disable iff (!rstn)
        state_reg != RHMS_ST_FUND && mode_latched == RHMS_MODE_EE_FO_ALT |->
            cfg.failover && cfg.eeprom_init &&
            cfg.upstream_port == ALT_UPSTREAM_PORT)
        else $error("mode A decoded wrongly");
    fund_reset_a: assert property (@(posedge clk) disable iff (!rstn)
        !fund_ok |=> ctl.link_fund_reset && !ctl.core_reset_n &&
            !ctl.smbus_enable && !halt_bit)
        else $error("fundamental reset not applied");
    strap_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        state_reg != RHMS_ST_FUND && $past(state_reg) != RHMS_ST_FUND |->
            $stable(mode_latched) && $stable(cfg))
        else $error("sampled mode changed outside reset");
    halt_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
        ctl.halted |-> !ctl.switch_enable && !ctl.core_reset_n &&
            ctl.smbus_enable && !eeprom_init_start)
        else $error("switching active while halted");
endmodule : rhms_top
`default_nettype wire

// ---- dv/rhms_board.sv ----
// rhms_board: board straps, fundamental reset pin, smbus master and
// eeprom loader in front of rhms_top; the testbench calls its tasks.
// assumes clk is the design's system clock.
`timescale 1ns/1ps
`default_nettype none
module rhms_board
    import rhms_pkg::*;
(
    input wire logic clk,                                // system clock
    output logic fundamental_reset_n,                    // reset pin
    output logic reset_hold_request,                     // halt strap
    output var rhms_pkg::rhms_mode_t operating_mode_strap, // mode straps
    output logic halt_bit_clear,                         // smbus clear
    output logic eeprom_init_done                        // load finished
);
    initial begin
        fundamental_reset_n = 1'b0;
        reset_hold_request = 1'b0;
        operating_mode_strap = 4'h0;
        halt_bit_clear = 1'b0;
        eeprom_init_done = 1'b0;
    end

    task automatic fund_assert(input rhms_mode_t m, input logic h);
        @(posedge clk);
        fundamental_reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        operating_mode_strap <= m;
        reset_hold_request <= h;
        repeat (6) @(posedge clk);
    endtask : fund_assert

    task automatic fund_release();
        @(posedge clk);
        fundamental_reset_n <= 1'b1;
    endtask : fund_release

    task automatic clear_halt();
        @(posedge clk);
        halt_bit_clear <= 1'b1;
        @(posedge clk);
        halt_bit_clear <= 1'b0;
    endtask : clear_halt

    task automatic load_done();
        @(posedge clk);
        eeprom_init_done <= 1'b1;
        @(posedge clk);
        eeprom_init_done <= 1'b0;
    endtask : load_done

    // straps moved after release only when the bench asks for it
    task automatic disturb(input rhms_mode_t m, input logic h);
        @(posedge clk);
        operating_mode_strap <= m;
        reset_hold_request <= h;
    endtask : disturb
endmodule : rhms_board
`default_nettype wire

// ---- dv/rhms_top_tb.sv ----
// rhms_top_tb: self-checking bench for rhms_top with a board model.
// assumes a short reset procedure parameter to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module rhms_top_tb;
    import rhms_pkg::*;
    localparam int RPC = 4;
    localparam rhms_port_t ALT_PORT = 4'h3;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    wire logic fundamental_reset_n;
    wire logic reset_hold_request;
    rhms_mode_t operating_mode_strap;
    wire logic halt_bit_clear;
    wire logic eeprom_init_done;
    rhms_ctl_t ctl;
    rhms_cfg_t cfg;
    rhms_mode_t mode_latched;
    logic halt_bit;
    logic eeprom_init_start;
    int n_fail = 0;
    int n_compared = 0;
    int seed = 89;

    always #4 clk = ~clk;

    rhms_board board (
        .clk(clk),
        .fundamental_reset_n(fundamental_reset_n),
        .reset_hold_request(reset_hold_request),
        .operating_mode_strap(operating_mode_strap),
        .halt_bit_clear(halt_bit_clear),
        .eeprom_init_done(eeprom_init_done)
    );

    rhms_top #(.RESET_PROC_CYCLES(RPC), .ALT_UPSTREAM_PORT(ALT_PORT)) DUT (
        .clk(clk),
        .rstn(rstn),
        .fundamental_reset_n(fundamental_reset_n),
        .reset_hold_request(reset_hold_request),
        .operating_mode_strap(operating_mode_strap),
        .halt_bit_clear(halt_bit_clear),
        .eeprom_init_done(eeprom_init_done),
        .ctl(ctl),
        .cfg(cfg),
        .mode_latched(mode_latched),
        .halt_bit(halt_bit),
        .eeprom_init_start(eeprom_init_start)
    );

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // reserved codes run as plain normal mode, flagged
    function automatic rhms_cfg_t exp_cfg(input rhms_mode_t m);
        rhms_cfg_t c;
        c = '0;
        case (m)
            4'h0: c = '0;
            4'h1: c.eeprom_init = 1'b1;
            4'h8: c.failover = 1'b1;
            4'h9: c = '{1'b1, 1'b1, 4'h0, 1'b0};
            4'hA: c = '{1'b1, 1'b1, ALT_PORT, 1'b0};
            default: c.reserved = 1'b1;
        endcase
        return c;
    endfunction : exp_cfg

    task automatic run_one(input int i, input rhms_mode_t m, input logic h);
        rhms_cfg_t e;
        int n;
        e = exp_cfg(m);
        board.fund_assert(m, h);
        #1;
        check("ctl_fund", {3'h0, ctl}, 8'h08);
        check("halt_bit_fund", {7'h0, halt_bit}, 8'h00);
        board.fund_release();
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ctl.link_fund_reset && n < 50);
        @(posedge clk);
        #1;
        check("mode_latched", {4'h0, mode_latched}, {4'h0, m});
        check("cfg", {1'b0, cfg}, {1'b0, e});
        check("halt_bit", {7'h0, halt_bit}, {7'h0, h});
        n = 1;
        while (!(ctl.core_reset_n || ctl.halted) && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("init_len", 8'(n), 8'(RPC));
        if (h) begin
            check("ctl_halt", {3'h0, ctl}, 8'h05);
            board.disturb(~m, ~h);
            repeat (3) @(posedge clk);
            #1;
            check("ctl_hold", {3'h0, ctl}, 8'h05);
            board.clear_halt();
            #1;
            check("halt_bit_clr", {7'h0, halt_bit}, 8'h00);
            check("ctl_clr", {3'h0, ctl}, 8'h05);
            @(posedge clk);
            #1;
        end
        if (e.eeprom_init) begin
            check("ctl_eeprom", {3'h0, ctl}, 8'h14);
            check("start", {7'h0, eeprom_init_start}, 8'h01);
            @(posedge clk);
            #1;
            check("start_end", {7'h0, eeprom_init_start}, 8'h00);
            board.load_done();
            @(posedge clk);
            #1;
        end
        board.disturb(~m, ~h);
        // a strap change needs four edges to reach the sampler
        repeat (5) @(posedge clk);
        #1;
        check("ctl_run", {3'h0, ctl}, 8'h16);
        check("mode_held", {4'h0, mode_latched}, {4'h0, m});
        check("cfg_held", {1'b0, cfg}, {1'b0, e});
        $display("test %0d mode %h hold %0d done", i, m, h);
    endtask : run_one

    initial begin
        logic [31:0] r;
        rhms_mode_t corner [10];
        rhms_mode_t legal [5];
        corner = '{4'h0, 4'h1, 4'h2, 4'h7, 4'h8,
                   4'h9, 4'hA, 4'hF, 4'hA, 4'h9};
        legal = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hA};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 10; i++)
            run_one(i, corner[i], 1'(i % 2));
        for (int i = 10; i < 24; i++) begin
            r = $random(seed);
            // random straps stay off reserved codes
            run_one(i, legal[r[7:0] % 8'h05], r[8]);
        end
        report_and_stop();
    end

    // hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
endmodule : rhms_top_tb
`default_nettype wire
